/* logic/ssc_pkg.sv */
// Purpose: Shared constants and types of the serial SRAM client front end.
// Assumes: One system clock; every link pin is sampled by that clock.
// Notes:   Instruction codes, transfer modes and lane widths live here only.
package ssc_pkg;

    // Array geometry.
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 8;
    localparam int PAGE_OFS_W = 5;

    // Instruction codes.
    localparam logic [7:0] CMD_READ    = 8'h03;
    localparam logic [7:0] CMD_WRITE   = 8'h02;
    localparam logic [7:0] CMD_DUAL    = 8'h3B;
    localparam logic [7:0] CMD_QUAD    = 8'h38;
    localparam logic [7:0] CMD_SINGLE  = 8'hFF;
    localparam logic [7:0] CMD_MODE_RD = 8'h05;
    localparam logic [7:0] CMD_MODE_WR = 8'h01;

    // Transfer mode field, bits 7 and 6 of the mode register.
    localparam int         MODE_FIELD_LSB = 6;
    localparam logic [1:0] XFER_BYTE      = 2'h0;
    localparam logic [1:0] XFER_PAGE      = 2'h2;
    localparam logic [1:0] XFER_SEQ       = 2'h1;
    localparam logic [1:0] XFER_RSVD      = 2'h3;
    localparam logic [1:0] MODE_RESET     = XFER_SEQ;
    localparam logic [5:0] MODE_RSVD_BITS = 6'h00;

    // Bits moved per serial clock and bits per byte.
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] STEP_SINGLE   = 4'h1;
    localparam logic [3:0] STEP_DUAL     = 4'h2;
    localparam logic [3:0] STEP_QUAD     = 4'h4;

    // Lanes driven while shifting out.
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_DUAL   = 4'h3;
    localparam logic [3:0] OE_QUAD   = 4'hF;

    // Write buffer depth.
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        LANE_SINGLE = 2'b00,
        LANE_DUAL   = 2'b01,
        LANE_QUAD   = 2'b10
    } ssc_lane_e;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_CMD      = 3'b001,
        ST_ADDR     = 3'b010,
        ST_WDATA    = 3'b011,
        ST_RDATA    = 3'b100,
        ST_MODE_IN  = 3'b101,
        ST_MODE_OUT = 3'b110,
        ST_DONE     = 3'b111
    } ssc_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ssc_wr_s;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } ssc_pins_s;

    // Deselected, clock low, pause line high.
    localparam ssc_pins_s PINS_IDLE = 6'h28;

endpackage

/* logic/ssc_fifo.sv */
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Output data come straight from the storage flops at the read pointer.
`timescale 1ns/1ns
`default_nettype none
module ssc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    wire              push;
    wire              pop;

    assign in_ready  = (count != FULL_CNT);
    assign out_valid = (count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = store[rd_ptr];

    always_ff @(posedge clk)
    begin
        if (push)
            store[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            count <= '0;
        else if (push && !pop)
            count <= count + 1'b1;
        else if (pop && !push)
            count <= count - 1'b1;
    end
endmodule // ssc_fifo
`default_nettype wire

/* logic/ssc_spi_client.sv */
// Purpose: Command front end of a 64 KB serial SRAM on a four-wire serial link.
// Assumes: Link pins are asynchronous; the serial clock is at most an eighth of clk.
// Notes:   The array itself sits outside; reads and writes go out on plain ports.
// Behaviour
// - Capture eight-bit instruction on rising clock edges.
// - All fields shift most significant bit first.
// - Mode bits 7:6 choose byte, page, sequential.
// - Sequential mode is the default after reset.
// - Byte mode moves exactly one data byte.
// - Page mode keeps bytes inside 32-byte page.
// - Page counter wraps to page start.
// - Sequential counter ignores pages, rolls to zero.
// - Read shifts out byte at given address.
// - Read pointer advances after each byte out.
// - Page writes beyond 32 bytes overwrite page.
// - Decode read 03h and write 02h.
// - Decode enter dual, enter quad, return single.
// - Mode register read 05h, write 01h.
// - Mode bits 5:0 reserved, read as zero.
// - Stay standby until falling select edge.
// - Deselected: standby, output driver released.
// - Sample on rising edge, drive after falling.
// - Wide lanes share pins; quad disables pause.
// - Dual mode moves two bits per clock.
// - Quad mode moves one nibble per clock.
// - Pause low suspends sequence, releases output.
`timescale 1ns/1ns
`default_nettype none
module ssc_spi_client #(
    parameter int FIFO_DEPTH = ssc_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset,
    // Link pins
    input  wire logic                           cs_n,
    input  wire logic                           sck,
    input  wire logic [3:0]                     io_in,
    output logic      [3:0]                     io_out,
    output logic      [3:0]                     io_oe,
    // Array read port
    output logic                                mem_rd_req,
    output logic      [ssc_pkg::ADDR_W-1:0]     mem_rd_addr,
    input  wire logic                           mem_rd_valid,
    input  wire logic [ssc_pkg::DATA_W-1:0]     mem_rd_data,
    // Array write port
    output logic                                mem_wr_valid,
    input  wire logic                           mem_wr_ready,
    output var ssc_pkg::ssc_wr_s                mem_wr,
    // Status
    output logic                                wr_overflow,
    output ssc_pkg::ssc_lane_e                  lane_mode,
    output logic      [1:0]                     transfer_mode
);
    ssc_pkg::ssc_pins_s  pin_s1;
    ssc_pkg::ssc_pins_s  pin_s2;
    ssc_pkg::ssc_state_e state;
    ssc_pkg::ssc_state_e next_state;
    ssc_pkg::ssc_wr_s    wr_item;

    logic                       sck_d;
    logic                       cs_d;
    logic                       paused;
    logic [7:0]                 sh_in;
    logic [3:0]                 bit_cnt;
    logic [ssc_pkg::ADDR_W-1:0] addr;
    logic                       addr_lo;
    logic                       op_read;
    logic [1:0]                 mode_pend;
    logic                       pend_v;
    logic [7:0]                 pend_byte;
    logic [7:0]                 out_sh;
    logic [3:0]                 out_cnt;
    logic                       out_active;
    logic                       last_out;
    logic                       fifo_in_ready;

    // Synchroniser: the second stage is the only reader of the first.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_s1 <= ssc_pkg::PINS_IDLE;
            pin_s2 <= ssc_pkg::PINS_IDLE;
            sck_d  <= 1'b0;
            cs_d   <= 1'b1;
        end
        else
        begin
            pin_s1 <= {cs_n, sck, io_in};
            pin_s2 <= pin_s1;
            sck_d  <= pin_s2.sck;
            cs_d   <= pin_s2.cs_n;
        end
    end

    wire selected = ~pin_s2.cs_n;
    wire cs_fall  = cs_d & ~pin_s2.cs_n;
    wire cs_rise  = ~cs_d & pin_s2.cs_n;
    wire rise_ok  = pin_s2.sck & ~sck_d & selected & ~paused;
    wire fall_ok  = ~pin_s2.sck & sck_d & selected & ~paused;

    wire is_dual = (lane_mode == ssc_pkg::LANE_DUAL);
    wire is_quad = (lane_mode == ssc_pkg::LANE_QUAD);
    wire [3:0] step = is_quad ? ssc_pkg::STEP_QUAD :
                      is_dual ? ssc_pkg::STEP_DUAL : ssc_pkg::STEP_SINGLE;
    wire [3:0] lane_oe = is_quad ? ssc_pkg::OE_QUAD :
                         is_dual ? ssc_pkg::OE_DUAL : ssc_pkg::OE_SINGLE;

    // Incoming bits enter at the bottom, so the first bit ends up on top.
    wire [7:0] in_shift = is_quad ? {sh_in[3:0], pin_s2.io} :
                          is_dual ? {sh_in[5:0], pin_s2.io[1:0]} :
                                    {sh_in[6:0], pin_s2.io[0]};
    wire [3:0] next_cnt  = bit_cnt + step;
    wire       byte_done = rise_ok && (next_cnt == ssc_pkg::BITS_PER_BYTE);

    wire       xfer_byte = (transfer_mode == ssc_pkg::XFER_BYTE);
    wire       xfer_page = (transfer_mode == ssc_pkg::XFER_PAGE);
    wire [7:0] mode_byte = {transfer_mode, ssc_pkg::MODE_RSVD_BITS};

    // Page mode wraps inside the page; otherwise the counter rolls over the array.
    wire [ssc_pkg::PAGE_OFS_W-1:0] page_ofs = addr[ssc_pkg::PAGE_OFS_W-1:0] + 1'b1;
    wire [ssc_pkg::ADDR_W-1:0] addr_after =
        xfer_page ? {addr[ssc_pkg::ADDR_W-1:ssc_pkg::PAGE_OFS_W], page_ofs} :
                    addr + 16'h0001;

    wire        out_state = (state == ssc_pkg::ST_RDATA) || (state == ssc_pkg::ST_MODE_OUT);
    wire        shift_out = fall_ok && out_state && !last_out;
    wire [7:0]  cur_out   = (out_cnt == 4'h0) ? pend_byte : out_sh;
    wire [7:0]  cur_shift = is_quad ? {cur_out[3:0], 4'h0} :
                            is_dual ? {cur_out[5:0], 2'h0} : {cur_out[6:0], 1'b0};
    wire [3:0]  lane_bits = is_quad ? cur_out[7:4] :
                            is_dual ? {2'h0, cur_out[7:6]} :
                                      {2'h0, cur_out[7], 1'b0};
    wire [3:0]  out_next  = out_cnt + step;
    wire        out_end   = shift_out && (out_next == ssc_pkg::BITS_PER_BYTE);
    wire        rd_first  = byte_done && (state == ssc_pkg::ST_ADDR) && addr_lo && op_read;
    wire        rd_more   = out_end && (state == ssc_pkg::ST_RDATA) && !xfer_byte;
    wire        push      = byte_done && (state == ssc_pkg::ST_WDATA);

    // Sequence decoding at the end of each received byte.
    always_comb
    begin
        next_state = state;
        unique case (state)
            ssc_pkg::ST_CMD:
            begin
                unique case (in_shift)
                    ssc_pkg::CMD_READ:    next_state = ssc_pkg::ST_ADDR;
                    ssc_pkg::CMD_WRITE:   next_state = ssc_pkg::ST_ADDR;
                    ssc_pkg::CMD_MODE_RD: next_state = ssc_pkg::ST_MODE_OUT;
                    ssc_pkg::CMD_MODE_WR: next_state = ssc_pkg::ST_MODE_IN;
                    default:              next_state = ssc_pkg::ST_DONE;
                endcase
            end
            ssc_pkg::ST_ADDR:
                next_state = !addr_lo ? ssc_pkg::ST_ADDR :
                             op_read  ? ssc_pkg::ST_RDATA : ssc_pkg::ST_WDATA;
            ssc_pkg::ST_WDATA:
                next_state = xfer_byte ? ssc_pkg::ST_DONE : ssc_pkg::ST_WDATA;
            ssc_pkg::ST_MODE_IN:
                next_state = ssc_pkg::ST_DONE;
            ssc_pkg::ST_IDLE,
            ssc_pkg::ST_RDATA,
            ssc_pkg::ST_MODE_OUT,
            ssc_pkg::ST_DONE:
                next_state = state;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset || !selected)
            state <= ssc_pkg::ST_IDLE;
        else if (cs_fall)
            state <= ssc_pkg::ST_CMD;
        else if (byte_done)
            state <= next_state;
        else if (fall_ok && last_out)
            state <= ssc_pkg::ST_DONE;
    end

    // Pause only takes hold or lets go while the serial clock is low.
    always_ff @(posedge clk)
    begin
        if (reset || !selected || is_quad)
            paused <= 1'b0;
        else if (!pin_s2.sck)
            paused <= ~pin_s2.io[3];
    end

    always_ff @(posedge clk)
    begin
        if (reset || !selected)
        begin
            sh_in   <= 8'h00;
            bit_cnt <= 4'h0;
        end
        else if (rise_ok)
        begin
            sh_in   <= in_shift;
            bit_cnt <= byte_done ? 4'h0 : next_cnt;
        end
    end

    // The width change takes effect right after the instruction byte.
    always_ff @(posedge clk)
    begin
        if (reset)
            lane_mode <= ssc_pkg::LANE_SINGLE;
        else if (byte_done && (state == ssc_pkg::ST_CMD))
        begin
            if (in_shift == ssc_pkg::CMD_DUAL)
                lane_mode <= ssc_pkg::LANE_DUAL;
            else if (in_shift == ssc_pkg::CMD_QUAD)
                lane_mode <= ssc_pkg::LANE_QUAD;
            else if (in_shift == ssc_pkg::CMD_SINGLE)
                lane_mode <= ssc_pkg::LANE_SINGLE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset || cs_fall)
        begin
            addr_lo <= 1'b0;
            op_read <= 1'b0;
        end
        else if (byte_done && (state == ssc_pkg::ST_CMD))
            op_read <= (in_shift == ssc_pkg::CMD_READ);
        else if (byte_done && (state == ssc_pkg::ST_ADDR))
            addr_lo <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            addr <= 16'h0000;
        else if (byte_done && (state == ssc_pkg::ST_ADDR) && !addr_lo)
            addr[15:8] <= in_shift;
        else if (byte_done && (state == ssc_pkg::ST_ADDR))
            addr[7:0] <= in_shift;
        else if (push || rd_more)
            addr <= addr_after;
    end

    // A written mode waits for the end of the operation, so a running access keeps its mode.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            transfer_mode <= ssc_pkg::MODE_RESET;
            mode_pend     <= ssc_pkg::MODE_RESET;
            pend_v        <= 1'b0;
        end
        else if (byte_done && (state == ssc_pkg::ST_MODE_IN))
        begin
            mode_pend <= in_shift[7:ssc_pkg::MODE_FIELD_LSB];
            pend_v    <= 1'b1;
        end
        else if (cs_rise && pend_v)
        begin
            transfer_mode <= mode_pend;
            pend_v        <= 1'b0;
        end
    end

    // Array read requests: one at the end of the address, one after each byte out except in byte mode.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mem_rd_req  <= 1'b0;
            mem_rd_addr <= 16'h0000;
        end
        else
        begin
            mem_rd_req <= rd_first || rd_more;
            if (rd_first)
                mem_rd_addr <= {addr[15:8], in_shift};
            else if (rd_more)
                mem_rd_addr <= addr_after;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            pend_byte <= 8'h00;
        else if (mem_rd_valid)
            pend_byte <= mem_rd_data;
        else if (byte_done && (state == ssc_pkg::ST_CMD) && (in_shift == ssc_pkg::CMD_MODE_RD))
            pend_byte <= mode_byte;
    end

    // New data go out only after a falling edge; the last bits stay until the next one.
    always_ff @(posedge clk)
    begin
        if (reset || !selected)
        begin
            io_out     <= 4'h0;
            out_sh     <= 8'h00;
            out_cnt    <= 4'h0;
            out_active <= 1'b0;
            last_out   <= 1'b0;
        end
        else if (shift_out)
        begin
            io_out     <= lane_bits;
            out_sh     <= cur_shift;
            out_cnt    <= out_end ? 4'h0 : out_next;
            out_active <= 1'b1;
            last_out   <= out_end && (state == ssc_pkg::ST_RDATA) && xfer_byte;
        end
        else if (fall_ok && last_out)
        begin
            out_active <= 1'b0;
            last_out   <= 1'b0;
        end
    end

    // The driver lets go at once on deselect or pause.
    assign io_oe = (out_active && !paused && selected) ? lane_oe : 4'h0;

    // Written bytes queue up for the array; select rising simply stops the queue filling.
    assign wr_item = '{addr: addr, data: in_shift};

    always_ff @(posedge clk)
    begin
        if (reset)
            wr_overflow <= 1'b0;
        else if (push && !fifo_in_ready)
            wr_overflow <= 1'b1;
        else if (cs_fall)
            wr_overflow <= 1'b0;
    end

    ssc_fifo #(
        .WIDTH ($bits(ssc_pkg::ssc_wr_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_item),
        .out_valid (mem_wr_valid),
        .out_ready (mem_wr_ready),
        .out_data  (mem_wr)
    );
endmodule // ssc_spi_client
`default_nettype wire

/* dv/ssc_spi_client_properties.sv */
// Purpose: Port checks of the serial SRAM client.
// Assumes: The host waits some clocks around every select edge.
// Notes:   Fetch addresses are compared within one frame only.
`timescale 1ns/1ns
`default_nettype none
module ssc_spi_client_properties #(
    parameter int FIFO_DEPTH = 8
) (
    // Clock, reset and link
    input wire logic               clk, reset, cs_n, sck,
    input wire logic [3:0]         io_in, io_out, io_oe,
    // Array side
    input wire logic               mem_rd_req, mem_rd_valid, mem_wr_valid, mem_wr_ready,
    input wire logic [15:0]        mem_rd_addr,
    input wire logic [7:0]         mem_rd_data,
    input wire ssc_pkg::ssc_wr_s   mem_wr,
    // Status
    input wire logic               wr_overflow,
    input wire ssc_pkg::ssc_lane_e lane_mode,
    input wire logic [1:0]         transfer_mode
);
    logic        have_req;
    logic [15:0] last_addr;
    logic [3:0]  oe_exp;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    assign oe_exp = lane_mode == ssc_pkg::LANE_QUAD ? ssc_pkg::OE_QUAD :
                    lane_mode == ssc_pkg::LANE_DUAL ? ssc_pkg::OE_DUAL : ssc_pkg::OE_SINGLE;
    // The raw pin marks frames; the host leaves slack, so no fetch straddles it.
    always_ff @(posedge clk)
    begin
        have_req  <= !(reset || cs_n) && (have_req || mem_rd_req);
        last_addr <= mem_rd_req ? mem_rd_addr : last_addr;
    end
    sequence s_desel;
        cs_n [*8];
    endsequence
    sequence s_again(logic [1:0] m);
        mem_rd_req && have_req && transfer_mode == m;
    endsequence
    sequence s_paused;
        (!cs_n && !sck && !io_in[3] && lane_mode != ssc_pkg::LANE_QUAD) [*4];
    endsequence
    property p_pause;
        s_paused |-> io_oe == 4'h0;
    endproperty
    property p_desel;
        s_desel |-> io_oe == 4'h0 && !mem_rd_req;
    endproperty
    property p_oe_lane;
        io_oe != 4'h0 |-> io_oe == oe_exp;
    endproperty
    property p_seq;
        s_again(ssc_pkg::XFER_SEQ) |-> mem_rd_addr == last_addr + 16'h1;
    endproperty
    property p_page;
        s_again(ssc_pkg::XFER_PAGE) |-> mem_rd_addr == {last_addr[15:5], last_addr[4:0] + 5'h1};
    endproperty
    property p_byte;
        mem_rd_req && transfer_mode == ssc_pkg::XFER_BYTE |-> !have_req;
    endproperty
    property p_default;
        $fell(reset) |-> transfer_mode == ssc_pkg::XFER_SEQ && lane_mode == ssc_pkg::LANE_SINGLE;
    endproperty
    property p_mode_cs;
        $changed(transfer_mode) |-> $past(cs_n) && $past(cs_n, 3);
    endproperty
    property p_lane;
        $changed(lane_mode) |-> !$past(cs_n) && !$past(cs_n, 3);
    endproperty
    property p_wr_hold;
        mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr);
    endproperty
    a_desel: assert property (p_desel) else $error("active while idle");
    a_oe_lane: assert property (p_oe_lane) else $error("bad enables");
    a_seq: assert property (p_seq) else $error("bad next address");
    a_page: assert property (p_page) else $error("bad page address");
    a_byte: assert property (p_byte) else $error("second fetch");
    a_default: assert property (p_default) else $error("bad reset mode");
    a_mode_cs: assert property (p_mode_cs) else $error("mode changed in frame");
    a_lane: assert property (p_lane) else $error("lane changed outside frame");
    a_wr_hold: assert property (p_wr_hold) else $error("write entry moved");
    a_pause: assert property (p_pause) else $error("driving while paused");
endmodule // ssc_spi_client_properties
bind ssc_spi_client ssc_spi_client_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .mem_rd_req(mem_rd_req), .mem_rd_valid(mem_rd_valid),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr(mem_wr), .wr_overflow(wr_overflow),
    .lane_mode(lane_mode), .transfer_mode(transfer_mode));
`default_nettype wire

/* dv/ssc_host_model.sv */
// Purpose: Host side of the serial link, driving select, clock and lanes.
// Assumes: Serial clock of 400 ns, idle low, edges just after clk.
// Notes:   Lane width w is set by the bench after each lane command.
`timescale 1ns/1ns
`default_nettype none
module ssc_host_model (
    // Clock and line view
    input wire logic  clk,
    input wire logic [3:0] io,
    // Driven pins
    output logic      cs_n,
    output logic      sck,
    output logic [3:0] drv
);
    int w = 1;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        drv = 4'hF;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Clock stays low around select edges so no stray edge is taken.
    task automatic sel(input logic on);
        tick(8);
        cs_n = !on;
        drv = 4'hF;
        tick(8);
    endtask
    // Pause moves with the clock low; the pulse while paused must be ignored.
    task automatic pause(input logic on);
        drv[3] = !on;
        tick(8);
        sck = on;
        tick(8);
        sck = 1'b0;
        tick(8);
    endtask
    // Pause line stays high outside quad width.
    task automatic xb(input logic [7:0] d, output logic [7:0] q);
        logic [7:0] s;
        s = d;
        q = 8'h00;
        for (int i = 0; i < 8; i += w)
        begin
            drv = w == 4 ? s[7:4] : w == 2 ? {2'b11, s[7:6]} : {3'b111, s[7]};
            tick(4);
            sck = 1'b1;
            q = w == 4 ? {q[3:0], io} : w == 2 ? {q[5:0], io[1:0]} : {q[6:0], io[1]};
            s = s << w;
            tick(4);
            sck = 1'b0;
        end
    endtask
endmodule // ssc_host_model
`default_nettype wire

/* dv/ssc_spi_client_tb.sv */
// Purpose: Self-checking bench of the serial SRAM client.
// Assumes: The array answers one clk after a fetch request.
// Notes:   Expected contents are kept apart from the array model.
`timescale 1ns/1ns
`default_nettype none
module ssc_spi_client_tb;
    logic clk, reset, cs_n, sck, wr_rdy, stall, mem_rd_req, mem_rd_valid, mem_wr_valid, wr_overflow;
    logic [3:0] drv, io_in, io_out, io_oe;
    logic [15:0] mem_rd_addr;
    logic [7:0] mem_rd_data, q;
    logic [1:0] transfer_mode, cur;
    ssc_pkg::ssc_wr_s mem_wr;
    ssc_pkg::ssc_lane_e lane_mode;
    logic [7:0] mem [0:65535];
    logic [7:0] ref_m [0:65535];
    int n_mismatch, n_checks, cyc;
    assign io_in = (io_oe & io_out) | (~io_oe & drv);
    ssc_spi_client #(.FIFO_DEPTH(8)) u_dut (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .mem_rd_req(mem_rd_req),
        .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(wr_rdy), .mem_wr(mem_wr),
        .wr_overflow(wr_overflow), .lane_mode(lane_mode), .transfer_mode(transfer_mode));
    ssc_host_model u_host (.clk(clk), .io(io_in), .cs_n(cs_n), .sck(sck), .drv(drv));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Array model; read data is scrambled between fetches and the write port stalls.
    always @(posedge clk)
    begin
        mem_rd_valid <= #1 mem_rd_req;
        mem_rd_data <= #1 mem_rd_req ? mem[mem_rd_addr] : 8'(cyc);
        wr_rdy <= #1 !stall && !cyc[2];
        if (mem_wr_valid && wr_rdy)
            mem[mem_wr.addr] <= mem_wr.data;
        cyc <= cyc + 1;
        if (cyc > 60000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic fr(input logic [7:0] c, input logic [7:0] v);
        u_host.sel(1'b1);
        u_host.xb(c, q);
        u_host.xb(v, q);
        u_host.sel(1'b0);
    endtask
    task automatic xfer(input logic [7:0] c, input logic [15:0] a, input int n, input logic [7:0] d);
        u_host.sel(1'b1);
        u_host.xb(c, q);
        u_host.xb(a[15:8], q);
        u_host.xb(a[7:0], q);
        for (int i = 0; i < n; i++)
        begin
            u_host.xb(d + 8'(i), q);
            if (c == ssc_pkg::CMD_WRITE && (i == 0 || cur != ssc_pkg::XFER_BYTE))
                ref_m[a] = d + 8'(i);
            else if (i == 0 || cur != ssc_pkg::XFER_BYTE)
                chk(q, ref_m[a]);
            a = cur == ssc_pkg::XFER_PAGE ? {a[15:5], a[4:0] + 5'h1} : a + 16'h1;
        end
        u_host.sel(1'b0);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        reset = 1'b1;
        stall = 1'b0;
        cur = ssc_pkg::XFER_SEQ;
        for (int i = 0; i < 65536; i++)
        begin
            mem[i] = 8'(i ^ (i >> 8));
            ref_m[i] = mem[i];
        end
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        u_host.tick(4);
        chk({4'h0, io_oe}, 8'h00);
        fr(ssc_pkg::CMD_MODE_RD, 8'h00);
        chk(q, {ssc_pkg::XFER_SEQ, 6'h00});
        for (int k = 0; k < 3; k++)
        begin
            cur = k == 0 ? ssc_pkg::XFER_BYTE : k == 1 ? ssc_pkg::XFER_PAGE : ssc_pkg::XFER_SEQ;
            fr(ssc_pkg::CMD_MODE_WR, {cur, 6'h00});
            fr(ssc_pkg::CMD_MODE_RD, 8'h00);
            chk(q, {cur, 6'h00});
            xfer(ssc_pkg::CMD_WRITE, 16'hFFFE, 34, 8'(8'h40 * k));
            xfer(ssc_pkg::CMD_READ, 16'hFFFE, 3, 8'h00);
        end
        for (int k = 1; k < 3; k++)
        begin
            fr(k == 1 ? ssc_pkg::CMD_DUAL : ssc_pkg::CMD_QUAD, 8'h00);
            u_host.w = 2 * k;
            chk({6'h00, lane_mode}, 8'(k));
            xfer(ssc_pkg::CMD_READ, 16'(k * 16'h1111), 2, 8'h00);
            xfer(ssc_pkg::CMD_WRITE, 16'(k * 16'h1111), 1, 8'hA5);
            chk(mem[16'(k * 16'h1111)], 8'hA5);
            fr(ssc_pkg::CMD_SINGLE, 8'h00);
            u_host.w = 1;
            chk({6'h00, lane_mode}, 8'h00);
        end
        // A pause in mid-read must keep the sequence going afterwards.
        u_host.sel(1'b1);
        u_host.xb(ssc_pkg::CMD_READ, q);
        u_host.xb(8'h30, q);
        u_host.xb(8'h00, q);
        u_host.xb(8'h00, q);
        chk(q, ref_m[16'h3000]);
        u_host.pause(1'b1);
        chk({4'h0, io_oe}, 8'h00);
        u_host.pause(1'b0);
        u_host.xb(8'h00, q);
        chk(q, ref_m[16'h3001]);
        u_host.sel(1'b0);
        stall = 1'b1;
        xfer(ssc_pkg::CMD_WRITE, 16'h2000, 9, 8'h60);
        // The ninth byte finds the buffer full and is dropped.
        ref_m[16'h2008] = 8'h28;
        chk({7'h00, wr_overflow}, 8'h01);
        stall = 1'b0;
        xfer(ssc_pkg::CMD_READ, 16'h2000, 9, 8'h00);
        stop_test();
    end
endmodule // ssc_spi_client_tb
`default_nettype wire
